// >>> cpag_params.svh
`ifndef CPAG_PARAMS_SVH
`define CPAG_PARAMS_SVH
`define CPAG_PC_AHEAD      32'h0000_0008
`define CPAG_WORD_STEP     32'h0000_0004
`define CPAG_OFS_SHIFT     2
`define CPAG_PC_REG        4'hf
`define CPAG_PC_LO         2
`define CPAG_PC_HI         25
`define CPAG_CNT_W         5
`define CPAG_CNT_ONE       5'h01
`define CPAG_PC_MASK       32'h03ff_fffc
`endif

// >>> cpag_pkg.sv
package cpag_pkg;
  typedef logic [31:0] cpag_word_t;
  typedef logic [3:0]  cpag_reg_t;
  typedef logic [7:0]  cpag_ofs_t;
  typedef enum logic [1:0] {CPAG_IDLE, CPAG_XFER} cpag_state_e;
endpackage : cpag_pkg

// >>> cpag_addr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cpag_addr_if;
  import cpag_pkg::*;
  cpag_word_t base;
  cpag_ofs_t  ofs;
  logic       up;
  logic       pre;
  cpag_word_t xfer_addr;
  cpag_word_t new_base;
  modport calc (input base, ofs, up, pre, output xfer_addr, new_base);
  modport user (output base, ofs, up, pre, input xfer_addr, new_base);
endinterface : cpag_addr_if
`default_nettype wire

// >>> cpag_offset_calc.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpag_params.svh"
module cpag_offset_calc (
  cpag_addr_if.calc a
);
  import cpag_pkg::*;
  cpag_word_t word_ofs;
  cpag_word_t moved;
  // Offset field is unsigned magnitude; direction picks add or subtract
  assign word_ofs = {22'h0, a.ofs, 2'b00};
  assign moved    = a.up ? a.base + word_ofs : a.base - word_ofs;
  assign a.xfer_addr = a.pre ? moved : a.base;
  assign a.new_base  = moved;
endmodule : cpag_offset_calc
`default_nettype wire

// >>> cpag_transfer_addr_gen.sv
// Contract
// - Pre-index: address is base plus signed offset
// - Zero offset pre-index uses base directly
// - Pre-index writes back only when requested
// - Post-index: base is address, offset after
// - Post-index always writes modified base back
// - PC base reads eight bytes ahead
// - Offset within 1024 bytes, word multiple
// - Scale eight-bit field by four, direction signed
// - Index bit picks pre/post; write-back bit stores
// - Following words step up four bytes
// - PC base excludes status flag bits
`timescale 1ns/1ps
`default_nettype none
`include "cpag_params.svh"
module cpag_transfer_addr_gen (
  input  wire logic              CLOCK,
  input  wire logic              SRST,
  input  wire logic              START,
  input  wire cpag_pkg::cpag_reg_t  BASE_SEL,
  input  wire cpag_pkg::cpag_word_t BASE_VALUE,
  input  wire cpag_pkg::cpag_word_t INSTR_ADDR,
  input  wire cpag_pkg::cpag_ofs_t  OFFSET,
  input  wire logic              UP,
  input  wire logic              PRE_INDEX,
  input  wire logic              WRITE_BACK,
  input  wire logic [4:0]        WORD_COUNT,
  output logic                   ADDR_VALID,
  output cpag_pkg::cpag_word_t   ADDR,
  output logic                   LAST,
  output logic                   WB_VALID,
  output cpag_pkg::cpag_reg_t    WB_REG,
  output cpag_pkg::cpag_word_t   WB_VALUE,
  output logic                   BUSY
);
  import cpag_pkg::*;
  cpag_addr_if ai ();
  cpag_state_e state_ff;
  cpag_word_t  pc_base;
  logic [`CPAG_CNT_W-1:0] left_ff;
  logic        do_wb;
  // PC carries flags in the upper and lower bits; only the address field is used
  assign pc_base = {6'h00, INSTR_ADDR[`CPAG_PC_HI:`CPAG_PC_LO], 2'b00}
                   + `CPAG_PC_AHEAD;
  assign ai.base = (BASE_SEL == `CPAG_PC_REG) ? pc_base : BASE_VALUE;
  assign ai.ofs  = OFFSET;
  assign ai.up   = UP;
  assign ai.pre  = PRE_INDEX;
  assign do_wb   = !PRE_INDEX || WRITE_BACK;
  cpag_offset_calc u_calc (.a(ai));
  logic start_ok;
  assign start_ok = START && (state_ff == CPAG_IDLE);
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_ff <= CPAG_IDLE;
      left_ff  <= '0;
    end else begin
      unique case (state_ff)
        CPAG_IDLE: begin
          if (START && WORD_COUNT > `CPAG_CNT_ONE) begin
            state_ff <= CPAG_XFER;
            left_ff  <= WORD_COUNT - `CPAG_CNT_ONE;
          end
        end
        CPAG_XFER: begin
          left_ff <= left_ff - `CPAG_CNT_ONE;
          if (left_ff == `CPAG_CNT_ONE) begin
            state_ff <= CPAG_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ADDR_VALID <= 1'b0;
      ADDR       <= '0;
      LAST       <= 1'b0;
    end else if (start_ok) begin
      ADDR_VALID <= 1'b1;
      ADDR       <= ai.xfer_addr;
      LAST       <= (WORD_COUNT <= `CPAG_CNT_ONE);
    end else if (state_ff == CPAG_XFER) begin
      ADDR_VALID <= 1'b1;
      ADDR       <= ADDR + `CPAG_WORD_STEP;
      LAST       <= (left_ff == `CPAG_CNT_ONE);
    end else begin
      ADDR_VALID <= 1'b0;
      LAST       <= 1'b0;
    end
  end
  // Base update once, alongside the first address, never per word
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      WB_VALID <= 1'b0;
      WB_REG   <= '0;
      WB_VALUE <= '0;
    end else begin
      WB_VALID <= start_ok && do_wb;
      if (start_ok) begin
        WB_REG   <= BASE_SEL;
        WB_VALUE <= ai.new_base;
      end
    end
  end
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= (start_ok && WORD_COUNT > `CPAG_CNT_ONE)
              || (state_ff == CPAG_XFER && left_ff != `CPAG_CNT_ONE);
    end
  end
  // Independent address model for the checks: built from the ports, not from the datapath
  cpag_word_t ref_base;
  cpag_word_t ref_ofs;
  cpag_word_t ref_moved;
  cpag_word_t ref_addr;
  assign ref_base  = (BASE_SEL == `CPAG_PC_REG)
                     ? (INSTR_ADDR & `CPAG_PC_MASK) + `CPAG_PC_AHEAD
                     : BASE_VALUE;
  assign ref_ofs   = 32'(OFFSET) << `CPAG_OFS_SHIFT;
  assign ref_moved = UP ? ref_base + ref_ofs : ref_base - ref_ofs;
  assign ref_addr  = PRE_INDEX ? ref_moved : ref_base;
  // Words seen since the accepted start, held against the requested count
  logic [`CPAG_CNT_W-1:0] seen_ff;
  logic [`CPAG_CNT_W-1:0] want_ff;
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      seen_ff <= '0;
    end else if (start_ok) begin
      seen_ff <= '0;
    end else if (ADDR_VALID) begin
      seen_ff <= seen_ff + `CPAG_CNT_ONE;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      want_ff <= '0;
    end else if (start_ok) begin
      want_ff <= (WORD_COUNT > `CPAG_CNT_ONE) ? WORD_COUNT : `CPAG_CNT_ONE;
    end
  end
  property p_first_addr;
    @(posedge CLOCK) disable iff (SRST)
      start_ok |=> ADDR_VALID && ADDR == $past(ai.xfer_addr);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first address wrong");
  property p_post_base;
    @(posedge CLOCK) disable iff (SRST)
      start_ok && !PRE_INDEX |=> ADDR == $past(ai.base) && WB_VALID;
  endproperty
  a_post_base: assert property (p_post_base) else $error("post index wrong");
  property p_pre_nowb;
    @(posedge CLOCK) disable iff (SRST)
      start_ok && PRE_INDEX && !WRITE_BACK |=> !WB_VALID;
  endproperty
  a_pre_nowb: assert property (p_pre_nowb) else $error("unwanted write-back");
  property p_step;
    @(posedge CLOCK) disable iff (SRST)
      ADDR_VALID && !LAST |=> ADDR_VALID && ADDR == $past(ADDR) + `CPAG_WORD_STEP;
  endproperty
  a_step: assert property (p_step) else $error("word step wrong");
  property p_wb_once;
    @(posedge CLOCK) disable iff (SRST)
      state_ff == CPAG_XFER |=> !WB_VALID;
  endproperty
  a_wb_once: assert property (p_wb_once) else $error("double write-back");
  property p_wb_val;
    @(posedge CLOCK) disable iff (SRST)
      start_ok && do_wb |=> WB_VALUE == $past(ai.new_base);
  endproperty
  a_wb_val: assert property (p_wb_val) else $error("write-back value wrong");
  property p_pc;
    @(posedge CLOCK) disable iff (SRST)
      start_ok && BASE_SEL == `CPAG_PC_REG && !PRE_INDEX |=>
        ADDR == {6'h00, $past(INSTR_ADDR[`CPAG_PC_HI:`CPAG_PC_LO]), 2'b00} + `CPAG_PC_AHEAD;
  endproperty
  a_pc: assert property (p_pc) else $error("pc base wrong");
  property p_zero_ofs;
    @(posedge CLOCK) disable iff (SRST)
      start_ok && PRE_INDEX && OFFSET == 8'h00 |=> ADDR == $past(ai.base);
  endproperty
  a_zero_ofs: assert property (p_zero_ofs) else $error("zero offset moved base");
  property p_ref_addr;
    @(posedge CLOCK) disable iff (SRST)
      start_ok |=> ADDR_VALID && ADDR == $past(ref_addr);
  endproperty
  a_ref_addr: assert property (p_ref_addr) else $error("address differs from model");
  property p_ref_wb;
    @(posedge CLOCK) disable iff (SRST)
      start_ok && (!PRE_INDEX || WRITE_BACK) |=>
        WB_VALID && WB_VALUE == $past(ref_moved) && WB_REG == $past(BASE_SEL);
  endproperty
  a_ref_wb: assert property (p_ref_wb) else $error("base update differs from model");
  property p_pre_wb;
    @(posedge CLOCK) disable iff (SRST)
      start_ok && PRE_INDEX && WRITE_BACK |=> WB_VALID && WB_VALUE == ADDR;
  endproperty
  a_pre_wb: assert property (p_pre_wb) else $error("pre-index base update wrong");
  property p_count;
    @(posedge CLOCK) disable iff (SRST)
      ADDR_VALID && LAST |-> seen_ff == want_ff - `CPAG_CNT_ONE;
  endproperty
  a_count: assert property (p_count) else $error("word count wrong");
  property p_single;
    @(posedge CLOCK) disable iff (SRST)
      start_ok && WORD_COUNT <= `CPAG_CNT_ONE |=> ADDR_VALID && LAST && !BUSY;
  endproperty
  a_single: assert property (p_single) else $error("single transfer not last");
  property p_last_busy;
    @(posedge CLOCK) disable iff (SRST)
      ADDR_VALID && LAST |-> !BUSY;
  endproperty
  a_last_busy: assert property (p_last_busy) else $error("busy on last word");
  // A start during a burst must neither restart the address nor update the base
  property p_refuse;
    @(posedge CLOCK) disable iff (SRST)
      START && state_ff == CPAG_XFER |=>
        !WB_VALID && ADDR_VALID && ADDR == $past(ADDR) + `CPAG_WORD_STEP;
  endproperty
  a_refuse: assert property (p_refuse) else $error("start taken during burst");
  c_pre_wb: cover property (@(posedge CLOCK) start_ok && PRE_INDEX && WRITE_BACK);
  c_post: cover property (@(posedge CLOCK) start_ok && !PRE_INDEX);
  c_long: cover property (@(posedge CLOCK) ADDR_VALID && !LAST ##1 ADDR_VALID && LAST);
  c_refused: cover property (@(posedge CLOCK) START && state_ff == CPAG_XFER);
  c_back: cover property (@(posedge CLOCK) start_ok ##1 start_ok);
endmodule : cpag_transfer_addr_gen
`default_nettype wire

// >>> cpag_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpag_mem_model (
  input  wire logic                 clk,
  input  wire logic                 addr_valid,
  input  wire cpag_pkg::cpag_word_t addr,
  input  wire logic                 wb_valid,
  output var  int                   words,
  output var  int                   wbs,
  output var  cpag_pkg::cpag_word_t last_addr
);
  import cpag_pkg::*;
  // Takes each word at once: the block has no stall input to push back on
  int         n_words = 0;
  int         n_wbs   = 0;
  cpag_word_t seen    = '0;
  assign words     = n_words;
  assign wbs       = n_wbs;
  assign last_addr = seen;
  always @(posedge clk) begin
    if (addr_valid) begin
      n_words <= n_words + 1;
      seen    <= addr;
    end
    if (wb_valid) begin
      n_wbs <= n_wbs + 1;
    end
  end
endmodule : cpag_mem_model
`default_nettype wire

// >>> cpag_transfer_addr_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpag_transfer_addr_gen_tb;
  import cpag_pkg::*;
  logic       clk, srst, start, up, pre, wb, av, last, wbv, busy;
  cpag_reg_t  sel, wreg;
  cpag_word_t base, pc, addr, wval, mlast;
  cpag_ofs_t  ofs;
  logic [4:0] cnt;
  int         errors, comparisons, cycles, mw, mb, w0, b0;
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  cpag_transfer_addr_gen cpag_transfer_addr_gen_inst (.CLOCK(clk), .SRST(srst), .START(start),
    .BASE_SEL(sel), .BASE_VALUE(base), .INSTR_ADDR(pc), .OFFSET(ofs), .UP(up),
    .PRE_INDEX(pre), .WRITE_BACK(wb), .WORD_COUNT(cnt), .ADDR_VALID(av), .ADDR(addr),
    .LAST(last), .WB_VALID(wbv), .WB_REG(wreg), .WB_VALUE(wval), .BUSY(busy));
  cpag_mem_model cpag_mem_model_inst (.clk(clk), .addr_valid(av), .addr(addr),
    .wb_valid(wbv), .words(mw), .wbs(mb), .last_addr(mlast));
  task automatic chk(input cpag_word_t got, input cpag_word_t exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Inputs change on the falling edge; first word is looked at in its own cycle
  task automatic go(input cpag_reg_t s, input cpag_word_t b, input cpag_ofs_t o,
                    input logic u, input logic p, input logic w, input logic [4:0] n);
    @(negedge clk);
    sel = s;
    base = b;
    ofs = o;
    up = u;
    pre = p;
    wb = w;
    cnt = n;
    start = 1;
    @(negedge clk);
    start = 0;
    chk(32'(av), 32'h0000_0001);
  endtask : go
  task automatic t_pre;
    go(4'h2, 32'h0000_1000, 8'h04, 1, 1, 1, 5'h01);
    chk(addr, 32'h0000_1010);
    chk(32'(wbv), 32'h0000_0001);
    chk(wval, 32'h0000_1010);
    chk(32'(wreg), 32'h0000_0002);
    chk(32'({last, busy}), 32'h0000_0002);
    $display("test pre done");
  endtask : t_pre
  task automatic t_post;
    go(4'h3, 32'h0000_2000, 8'h10, 0, 0, 0, 5'h01);
    chk(addr, 32'h0000_2000);
    chk(32'(wbv), 32'h0000_0001);
    chk(wval, 32'h0000_1fc0);
    go(4'h1, 32'h0000_3000, 8'h00, 1, 1, 0, 5'h01);
    chk(addr, 32'h0000_3000);
    chk(32'(wbv), 32'h0000_0000);
    $display("test post done");
  endtask : t_post
  // Flag bits set on both sides of the address field must not leak into the base
  task automatic t_pc;
    pc = 32'hfc00_1003;
    go(4'hf, 32'h0000_5555, 8'hff, 0, 1, 0, 5'h01);
    chk(addr, 32'h0000_0c0c);
    chk(32'(wbv), 32'h0000_0000);
    go(4'hf, 32'h0000_5555, 8'h02, 1, 0, 0, 5'h01);
    chk(addr, 32'h0000_1008);
    chk(wval, 32'h0000_1010);
    $display("test pc done");
  endtask : t_pc
  // The start raised mid-burst must be ignored
  task automatic t_burst;
    @(negedge clk);
    w0 = mw;
    b0 = mb;
    go(4'h5, 32'h0000_4000, 8'h01, 1, 0, 0, 5'h03);
    chk(addr, 32'h0000_4000);
    chk(32'({last, busy}), 32'h0000_0001);
    @(negedge clk);
    chk(addr, 32'h0000_4004);
    chk(32'({av, last, busy, wbv}), 32'h0000_000a);
    base = 32'h0000_9000;
    start = 1;
    @(negedge clk);
    start = 0;
    chk(addr, 32'h0000_4008);
    chk(32'({av, last, busy, wbv}), 32'h0000_000c);
    repeat (2) @(negedge clk);
    chk(32'(av), 32'h0000_0000);
    chk(mw - w0, 32'h0000_0003);
    chk(mlast, 32'h0000_4008);
    chk(mb - b0, 32'h0000_0001);
    $display("test burst done");
  endtask : t_burst
  // Single transfers may follow each other with start held high
  task automatic t_back;
    @(negedge clk);
    sel = 4'h6;
    base = 32'h0000_0100;
    ofs = 8'h01;
    up = 1;
    pre = 1;
    wb = 1;
    cnt = 5'h01;
    start = 1;
    @(negedge clk);
    chk(addr, 32'h0000_0104);
    chk(32'({av, wbv}), 32'h0000_0003);
    base = 32'h0000_0200;
    ofs = 8'h02;
    up = 0;
    @(negedge clk);
    start = 0;
    chk(addr, 32'h0000_01f8);
    chk(wval, 32'h0000_01f8);
    chk(32'({av, last, wbv}), 32'h0000_0007);
    $display("test back to back done");
  endtask : t_back
  // Reset in mid-burst must clear the outputs and leave the block ready
  task automatic t_reset;
    go(4'h4, 32'h0000_6000, 8'h00, 1, 0, 0, 5'h05);
    srst = 1;
    @(negedge clk);
    chk(32'({av, last, busy, wbv}), 32'h0000_0000);
    srst = 0;
    go(4'h4, 32'h0000_7000, 8'h00, 1, 1, 1, 5'h01);
    chk(addr, 32'h0000_7000);
    chk(32'({last, busy, wbv}), 32'h0000_0005);
    chk(wval, 32'h0000_7000);
    $display("test reset done");
  endtask : t_reset
  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      finish_test;
    end
  end
  initial begin
    {srst, start, up, pre, wb, sel, base, pc, ofs, cnt} = '0;
    {errors, comparisons} = '0;
    srst = 1;
    repeat (8) @(negedge clk);
    chk(32'({av, wbv, busy}), 32'h0000_0000);
    srst = 0;
    t_pre;
    t_post;
    t_pc;
    t_burst;
    t_back;
    t_reset;
    finish_test;
  end
endmodule : cpag_transfer_addr_gen_tb
`default_nettype wire
